// >>> rtl/csr_pkg.sv
/*
  Constants for the core status, option and interrupt register group:
  register addresses, alias masks, field positions, reset values and
  the ALU operation codes.
  Assumes a 9-bit data-memory address and 8-bit data.
*/
package csr_pkg;

  localparam int unsigned AW = 9;
  localparam int unsigned DW = 8;

  // Register addresses and the address bits compared for each
  localparam logic [8:0] STATUS_ADDR = 9'h003;
  localparam logic [8:0] IRQCTL_ADDR = 9'h00B;
  localparam logic [8:0] OPTION_ADDR = 9'h081;
  localparam logic [8:0] PIEN_ADDR   = 9'h08C;
  localparam logic [8:0] ANY_BANK_M  = 9'h07F;
  localparam logic [8:0] BANK_PAIR_M = 9'h0FF;
  localparam logic [8:0] ONE_BANK_M  = 9'h1FF;

  // Status fields
  localparam int unsigned ST_IBANK   = 7;
  localparam int unsigned ST_DBANK_H = 6;
  localparam int unsigned ST_DBANK_L = 5;
  localparam int unsigned ST_EXPIRY  = 4;
  localparam int unsigned ST_PWRDN   = 3;
  localparam int unsigned ST_Z       = 2;
  localparam int unsigned ST_DCARRY  = 1;
  localparam int unsigned ST_C       = 0;

  // Option fields
  localparam int unsigned OP_PU_OFF  = 7;
  localparam int unsigned OP_EDGE    = 6;
  localparam int unsigned OP_T0_SRC  = 5;
  localparam int unsigned OP_T0_FALL = 4;
  localparam int unsigned OP_PSC_WDT = 3;
  localparam int unsigned OP_PS_H    = 2;

  // Interrupt control fields
  localparam int unsigned IC_GLOBAL_EN = 7;
  localparam int unsigned IC_PERIPH_EN = 6;
  localparam int unsigned IC_T0IE      = 5;
  localparam int unsigned IC_EXT_EN    = 4;
  localparam int unsigned IC_CHG_EN    = 3;
  localparam int unsigned IC_T0IF      = 2;
  localparam int unsigned IC_EXT_FLAG  = 1;
  localparam int unsigned IC_CHG_FLAG  = 0;

  // Reset values
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] IRQCTL_RST = 8'h00;
  localparam logic [7:0] PIEN_RST   = 8'h00;

  typedef enum logic [2:0] {
    CSR_OP_ADD,
    CSR_OP_SUB,
    CSR_OP_LOGIC,
    CSR_OP_ROR,
    CSR_OP_ROL
  } csr_alu_op_t;

endpackage : csr_pkg

// >>> rtl/csr_alu_flags.sv
/*
  Combinational flag generator: zero, digit carry and carry for the
  operation the datapath is executing.
  Assumes operands are stable for the cycle the flags are taken.
*/
`timescale 1ns/100ps
module csr_alu_flags (
  input  wire logic [7:0]          a,
  input  wire logic [7:0]          b,
  input  wire csr_pkg::csr_alu_op_t op,
  input  wire logic                c_in,
  output logic      [2:0]          flags
);
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] res;

  always_comb begin
    sum = 9'h000;
    nib = 5'h00;
    res = a;
    flags = 3'h0;
    case (op)
      csr_pkg::CSR_OP_ADD: begin
        sum = {1'b0, a} + {1'b0, b};
        nib = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        res = sum[7:0];
        flags[csr_pkg::ST_C]  = sum[8];
        flags[csr_pkg::ST_DCARRY] = nib[4];
      end
      csr_pkg::CSR_OP_SUB: begin
        // Two's complement add, so carry set means no borrow
        sum = {1'b0, a} + {1'b0, ~b} + 9'h001;
        nib = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
        res = sum[7:0];
        flags[csr_pkg::ST_C]  = sum[8];
        flags[csr_pkg::ST_DCARRY] = nib[4];
      end
      csr_pkg::CSR_OP_ROR: begin
        res = {c_in, a[7:1]};
        flags[csr_pkg::ST_C] = a[0];
      end
      csr_pkg::CSR_OP_ROL: begin
        res = {a[6:0], c_in};
        flags[csr_pkg::ST_C] = a[7];
      end
      default: res = a;
    endcase
    flags[csr_pkg::ST_Z] = (res == 8'h00);
  end

endmodule : csr_alu_flags

// >>> rtl/csr_prescaler.sv
/*
  Shared prescaler, assigned either ahead of timer0 or behind the
  watchdog timer.
  Assumes every clock is one instruction cycle and that pin edges
  arrive already synchronised.
*/
`timescale 1ns/100ps
module csr_prescaler (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       src_ext,
  input  wire logic       fall_sel,
  input  wire logic       to_wdt,
  input  wire logic [2:0] rate,
  input  wire logic       pin_rise,
  input  wire logic       pin_fall,
  input  wire logic       wdt_osc,
  input  wire logic       wdt_kick,
  output logic            t0_inc,
  output logic            wdt_tick
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       t0;
    logic       wdt;
  } csr_psc_state_t;

  csr_psc_state_t q;
  csr_psc_state_t d;
  logic           t0_src;
  logic [7:0]     nxt;
  logic [7:0]     mask;

  always_comb begin
    d = q;
    t0_src = src_ext ? (fall_sel ? pin_fall : pin_rise) : 1'b1;
    nxt = q.cnt + 8'h01;
    // Timer0 takes 2^(n+1), the watchdog 2^n
    mask = to_wdt ? 8'((9'h001 << rate) - 9'h001)
                  : 8'((9'h002 << rate) - 9'h001);
    d.t0 = 1'b0;
    d.wdt = 1'b0;
    if (to_wdt) begin
      d.t0 = t0_src;
      if (wdt_kick) begin
        d.cnt = 8'h00;
      end else if (wdt_osc) begin
        d.cnt = nxt;
        d.wdt = ((nxt & mask) == 8'h00);
      end
    end else begin
      d.wdt = wdt_osc;
      if (t0_src) begin
        d.cnt = nxt;
        d.t0 = ((nxt & mask) == 8'h00);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign t0_inc = q.t0;
  assign wdt_tick = q.wdt;

endmodule : csr_prescaler

// >>> rtl/csr_core_regs.sv
/*
  Core special-function registers: ALU status and bank select, the
  timer and prescaler option register, the core interrupt control
  register and the first peripheral interrupt enable register, with
  the flag logic and interrupt request that hang off them.
  Assumes the instruction datapath drives the register port on the
  same clock, one instruction per clock, and that timer0, watchdog
  and port B live outside and talk through pulses and levels here.
*/
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Flag-updating instruction aimed at status keeps ALU flags, not data.
// - Software writes never change the expiry and power-down bits.
// - Indirect bank bit picks banks 2-3 when set, 0-1 when clear.
// - Two-bit direct bank field picks one of four 128-byte banks.
// - Expiry bit set at reset, kick or halt; cleared on watchdog time-out.
// - Power-down bit set at reset or kick; cleared by halt.
// - Zero flag follows whether the result is zero.
// - Digit carry is nibble carry; inverted sense as borrow on subtract.
// - Carry from top bit, borrow inverted; rotates load shifted-out bit.
// - Pull-up disable forces all off, else latch value per pin.
// - Edge select picks rising or falling edge of the external pin.
// - Source select clocks timer0 from its pin or the cycle clock.
// - Timer0 edge select picks falling or rising pin transitions.
// - Owner bit gives prescaler to watchdog when set, timer0 when clear.
// - Rate n divides timer0 by 2^(n+1), watchdog by 2^n.
// - Global enable clear blocks all interrupts; set passes enabled ones.
// - Peripheral sources also need the peripheral enable bit.
// - Flags set on their event regardless of any enable.
// - Core enables for timer0, external pin and port change gate flags.
// - Timer0 overflow and pin-edge flags stay set until software clears.
// - Port change flag re-sets while upper pins differ from last read.
// - Peripheral enable register holds eight enables, bit 7 to bit 0.
module csr_core_regs (
  input  wire logic                 CLK,
  input  wire logic                 SYS_RST,
  // Register access from the datapath
  input  wire logic [8:0]           REG_ADDR,
  input  wire logic                 REG_WR,
  input  wire logic [7:0]           REG_WDATA,
  input  wire logic                 REG_RD,
  output logic      [7:0]           REG_RDATA,
  // ALU flag update
  input  wire logic                 ALU_EN,
  input  wire csr_pkg::csr_alu_op_t ALU_OP,
  input  wire logic [7:0]           ALU_A,
  input  wire logic [7:0]           ALU_B,
  input  wire logic [2:0]           ALU_FLAG_MASK,
  output logic                      CARRY,
  // Bank selection
  input  wire logic [6:0]           DIRECT_OFFSET,
  input  wire logic [7:0]           INDIRECT_POINTER,
  output logic      [8:0]           DIRECT_ADDR,
  output logic      [8:0]           INDIRECT_ADDR,
  // Reset-status events
  input  wire logic                 KICK_EXEC,
  input  wire logic                 HALT_EXEC,
  input  wire logic                 WDT_TIMEOUT,
  // Timer0, watchdog and prescaler
  input  wire logic                 TIMER0_CLOCK_PIN,
  input  wire logic                 WDT_OSC_TICK,
  input  wire logic                 TIMER0_OVERFLOW,
  output logic                      TIMER0_INC,
  output logic                      WDT_TICK,
  // Port B
  input  wire logic                 EXT_INTERRUPT_PIN,
  input  wire logic [3:0]           PORT_B_UPPER_PINS,
  input  wire logic                 PORT_B_READ,
  input  wire logic [7:0]           PORT_B_LATCH,
  output logic      [7:0]           PULLUP_EN,
  // Interrupts
  input  wire logic [7:0]           PERIPH_FLAGS,
  output logic                      IRQ
);

  //////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] option;
    logic [7:0] irqctl;
    logic [7:0] pien;
    logic [7:0] rdata;
    logic       ext_s1;
    logic       ext_s2;
    logic       ext_prev;
    logic       t0_s1;
    logic       t0_s2;
    logic       t0_prev;
    logic [3:0] rb_s1;
    logic [3:0] rb_s2;
    logic [3:0] rb_last;
  } csr_core_state_t;

  csr_core_state_t q;
  csr_core_state_t d;

  //////////////////////////////////////////////////////////////////////
  // Address decode

  logic hit_status;
  logic hit_irqctl;
  logic hit_option;
  logic hit_pien;

  // Status and interrupt control answer in every bank
  assign hit_status = (REG_ADDR & csr_pkg::ANY_BANK_M)
                      == csr_pkg::STATUS_ADDR;
  assign hit_irqctl = (REG_ADDR & csr_pkg::ANY_BANK_M)
                      == csr_pkg::IRQCTL_ADDR;
  // Option appears in banks 1 and 3 only
  assign hit_option = (REG_ADDR & csr_pkg::BANK_PAIR_M)
                      == csr_pkg::OPTION_ADDR;
  assign hit_pien   = (REG_ADDR & csr_pkg::ONE_BANK_M)
                      == csr_pkg::PIEN_ADDR;

  //////////////////////////////////////////////////////////////////////
  // ALU flags and prescaler

  logic [2:0] alu_flags;

  csr_alu_flags u_flags (
    .a     (ALU_A),
    .b     (ALU_B),
    .op    (ALU_OP),
    .c_in  (q.status[csr_pkg::ST_C]),
    .flags (alu_flags)
  );

  logic t0_rise;
  logic t0_fall;

  assign t0_rise = q.t0_s2 & ~q.t0_prev;
  assign t0_fall = ~q.t0_s2 & q.t0_prev;

  csr_prescaler u_psc (
    .clk      (CLK),
    .rst      (SYS_RST),
    .src_ext  (q.option[csr_pkg::OP_T0_SRC]),
    .fall_sel (q.option[csr_pkg::OP_T0_FALL]),
    .to_wdt   (q.option[csr_pkg::OP_PSC_WDT]),
    .rate     (q.option[csr_pkg::OP_PS_H:0]),
    .pin_rise (t0_rise),
    .pin_fall (t0_fall),
    .wdt_osc  (WDT_OSC_TICK),
    .wdt_kick (KICK_EXEC),
    .t0_inc   (TIMER0_INC),
    .wdt_tick (WDT_TICK)
  );

  //////////////////////////////////////////////////////////////////////
  // Event detection

  logic ext_edge;
  logic rb_mismatch;

  // Edges are taken only from the second synchroniser stage
  assign ext_edge = q.option[csr_pkg::OP_EDGE]
                  ? (q.ext_s2 & ~q.ext_prev)
                  : (~q.ext_s2 & q.ext_prev);
  assign rb_mismatch = (q.rb_s2 != q.rb_last);

  //////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;

    d.ext_s1  = EXT_INTERRUPT_PIN;
    d.ext_s2  = q.ext_s1;
    d.ext_prev = q.ext_s2;
    d.t0_s1   = TIMER0_CLOCK_PIN;
    d.t0_s2   = q.t0_s1;
    d.t0_prev = q.t0_s2;
    d.rb_s1   = PORT_B_UPPER_PINS;
    d.rb_s2   = q.rb_s1;

    // Status: bank bits are plain data; expiry and power-down never
    if (REG_WR && hit_status) begin
      d.status[csr_pkg::ST_IBANK:csr_pkg::ST_DBANK_L] =
        REG_WDATA[csr_pkg::ST_IBANK:csr_pkg::ST_DBANK_L];
      for (int i = 0; i <= csr_pkg::ST_Z; i++) begin
        if (!(ALU_EN && ALU_FLAG_MASK[i])) begin
          d.status[i] = REG_WDATA[i];
        end
      end
    end

    // ALU result flags win over the data write in the same cycle
    if (ALU_EN) begin
      for (int i = 0; i <= csr_pkg::ST_Z; i++) begin
        if (ALU_FLAG_MASK[i]) begin
          d.status[i] = alu_flags[i];
        end
      end
    end

    if (KICK_EXEC) begin
      d.status[csr_pkg::ST_EXPIRY] = 1'b1;
      d.status[csr_pkg::ST_PWRDN] = 1'b1;
    end
    if (HALT_EXEC) begin
      d.status[csr_pkg::ST_EXPIRY] = 1'b1;
      d.status[csr_pkg::ST_PWRDN] = 1'b0;
    end
    // A time-out in the same cycle as a kick still reports expiry
    if (WDT_TIMEOUT) begin
      d.status[csr_pkg::ST_EXPIRY] = 1'b0;
    end

    if (REG_WR && hit_option) begin
      d.option = REG_WDATA;
    end

    if (REG_WR && hit_pien) begin
      d.pien = REG_WDATA;
    end

    if (REG_WR && hit_irqctl) begin
      d.irqctl = REG_WDATA;
    end

    // Hardware sets come after the write so a set beats a clear
    if (TIMER0_OVERFLOW) begin
      d.irqctl[csr_pkg::IC_T0IF] = 1'b1;
    end
    if (ext_edge) begin
      d.irqctl[csr_pkg::IC_EXT_FLAG] = 1'b1;
    end
    if (rb_mismatch) begin
      d.irqctl[csr_pkg::IC_CHG_FLAG] = 1'b1;
    end

    // Only a port read ends the mismatch; clearing alone re-sets
    if (PORT_B_READ) begin
      d.rb_last = q.rb_s2;
    end

    if (REG_RD) begin
      if (hit_status) begin
        d.rdata = q.status;
      end else if (hit_irqctl) begin
        d.rdata = q.irqctl;
      end else if (hit_option) begin
        d.rdata = q.option;
      end else if (hit_pien) begin
        d.rdata = q.pien;
      end else begin
        d.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      q <= '0;
      q.status <= csr_pkg::STATUS_RST;
      q.option <= csr_pkg::OPTION_RST;
      q.irqctl <= csr_pkg::IRQCTL_RST;
      q.pien <= csr_pkg::PIEN_RST;
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs

  assign REG_RDATA = q.rdata;
  assign CARRY = q.status[csr_pkg::ST_C];

  // Each bank is 128 bytes; the bank bits form the top of the address
  assign DIRECT_ADDR = {q.status[csr_pkg::ST_DBANK_H:csr_pkg::ST_DBANK_L],
                        DIRECT_OFFSET};
  assign INDIRECT_ADDR = {q.status[csr_pkg::ST_IBANK],
                          INDIRECT_POINTER};

  // Pin direction is not seen here, so a latch high on an output pin
  // still asks for its pull-up; the port must mask that itself
  assign PULLUP_EN = q.option[csr_pkg::OP_PU_OFF]
                   ? 8'h00 : PORT_B_LATCH;

  logic core_pend;
  logic periph_pend;

  assign core_pend =
      (q.irqctl[csr_pkg::IC_T0IE] & q.irqctl[csr_pkg::IC_T0IF])
    | (q.irqctl[csr_pkg::IC_EXT_EN] & q.irqctl[csr_pkg::IC_EXT_FLAG])
    | (q.irqctl[csr_pkg::IC_CHG_EN]
       & q.irqctl[csr_pkg::IC_CHG_FLAG]);

  assign periph_pend = q.irqctl[csr_pkg::IC_PERIPH_EN]
                     & (|(q.pien & PERIPH_FLAGS));

  assign IRQ = q.irqctl[csr_pkg::IC_GLOBAL_EN]
             & (core_pend | periph_pend);

endmodule : csr_core_regs

// >>> test/csr_core_model.sv
/*
  Datapath model: drives the register port and the ALU flag inputs of
  the core register group, one access per task call.
  Assumes the bench clock; all drives change on the falling edge.
*/
`timescale 1ns/100ps
module csr_core_model (
  input  wire logic            clk,
  input  wire logic [7:0]      rdata,
  output logic      [8:0]      addr,
  output logic                 wr,
  output logic      [7:0]      wdata,
  output logic                 rd,
  output logic                 alu_en,
  output csr_pkg::csr_alu_op_t alu_op,
  output logic      [7:0]      alu_a,
  output logic      [7:0]      alu_b,
  output logic      [2:0]      alu_mask
);
  initial begin
    addr     = 9'h1FF;
    wr       = 1'b0;
    wdata    = 8'h00;
    rd       = 1'b0;
    alu_en   = 1'b0;
    alu_op   = csr_pkg::CSR_OP_ADD;
    alu_a    = 8'h00;
    alu_b    = 8'h00;
    alu_mask = 3'h0;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
    @(negedge clk);
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    @(negedge clk);
    wr    = 1'b0;
    // Stale data must not look valid after the strobe
    wdata = ~d;
  endtask : wr_reg

  task automatic rd_reg(input logic [8:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd   = 1'b1;
    @(negedge clk);
    rd   = 1'b0;
    d    = rdata;
  endtask : rd_reg

  // Optional status write in the same cycle as the flag update
  task automatic alu_step(input csr_pkg::csr_alu_op_t op,
                          input logic [7:0] a, input logic [7:0] b,
                          input logic [2:0] m, input logic st_wr);
    @(negedge clk);
    alu_en   = 1'b1;
    alu_op   = op;
    alu_a    = a;
    alu_b    = b;
    alu_mask = m;
    addr     = 9'h003;
    wdata    = 8'h00;
    wr       = st_wr;
    @(negedge clk);
    alu_en   = 1'b0;
    wr       = 1'b0;
  endtask : alu_step
endmodule : csr_core_model

// >>> test/csr_core_regs_sva.sv
/*
  Port checker for the core register group.
  Assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/100ps
module csr_core_regs_chk (
  input wire logic                 CLK,
  input wire logic                 SYS_RST,
  input wire logic [8:0]           REG_ADDR,
  input wire logic                 REG_RD,
  input wire logic                 REG_WR,
  input wire logic [7:0]           REG_RDATA,
  input wire logic                 ALU_EN,
  input wire csr_pkg::csr_alu_op_t ALU_OP,
  input wire logic [7:0]           ALU_A,
  input wire logic [7:0]           ALU_B,
  input wire logic [2:0]           ALU_FLAG_MASK,
  input wire logic                 CARRY,
  input wire logic [6:0]           DIRECT_OFFSET,
  input wire logic [8:0]           DIRECT_ADDR,
  input wire logic [7:0]           INDIRECT_POINTER,
  input wire logic [8:0]           INDIRECT_ADDR,
  input wire logic [7:0]           PORT_B_LATCH,
  input wire logic [7:0]           PULLUP_EN
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  logic [8:0] sum;
  logic       add_c;
  logic       no_borrow;
  logic       unmapped;
  assign sum       = {1'b0, ALU_A} + {1'b0, ALU_B};
  assign add_c     = sum[8];
  assign no_borrow = ALU_A >= ALU_B;
  assign unmapped  = ((REG_ADDR & 9'h07F) != 9'h003)
                  && ((REG_ADDR & 9'h07F) != 9'h00B)
                  && ((REG_ADDR & 9'h0FF) != 9'h081)
                  && (REG_ADDR != 9'h08C);

  ////////////////////////////////////////////////////////////////////
  a_pullup_gate: assert property (PULLUP_EN == 8'h00
    || PULLUP_EN == PORT_B_LATCH) else $error("pull-up mix");
  a_direct_bank: assert property (
    DIRECT_ADDR[6:0] == DIRECT_OFFSET) else $error("direct offset lost");
  a_indirect_bank: assert property (
    INDIRECT_ADDR[7:0] == INDIRECT_POINTER)
    else $error("indirect pointer lost");
  a_unmapped_zero: assert property (REG_RD && unmapped |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data moved");
  a_add_carry: assert property (ALU_EN && ALU_OP == csr_pkg::CSR_OP_ADD
    && ALU_FLAG_MASK[0] |=> CARRY == $past(add_c)) else $error("add carry");
  a_sub_borrow: assert property (ALU_EN && ALU_OP == csr_pkg::CSR_OP_SUB
    && ALU_FLAG_MASK[0] |=> CARRY == $past(no_borrow)) else $error("sub carry");
  a_carry_keep: assert property (!ALU_EN && !REG_WR |=> $stable(CARRY))
    else $error("carry changed");
endmodule : csr_core_regs_chk

bind csr_core_regs csr_core_regs_chk i_chk (.CLK, .SYS_RST, .REG_ADDR,
  .REG_RD, .REG_WR, .REG_RDATA, .ALU_EN, .ALU_OP, .ALU_A, .ALU_B,
  .ALU_FLAG_MASK, .CARRY, .DIRECT_OFFSET, .DIRECT_ADDR, .INDIRECT_POINTER,
  .INDIRECT_ADDR, .PORT_B_LATCH, .PULLUP_EN);

// >>> test/csr_core_regs_test.sv
/*
  Self-checking bench for the core register group.
  Assumes the datapath model and the bound checker are compiled first.
*/
`timescale 1ns/100ps
module csr_core_regs_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic kick = 1'b0, halt = 1'b0, wdto = 1'b0, t0pin = 1'b0, t0ov = 1'b0;
  logic extp = 1'b0, pbr = 1'b0;
  logic [3:0] pbu = 4'h0;
  logic [6:0] offs = 7'h55;
  logic [7:0] ptr = 8'hA3, latch = 8'hA5, pflags = 8'h00, v;
  logic [8:0] addr, daddr, iaddr;
  logic [7:0] wdata, rdata, a, b, pull;
  logic [2:0] m;
  logic wr, rd, alu_en, carry, t0inc, wtick, irq;
  csr_pkg::csr_alu_op_t op;
  int miscompares = 0, n_tests = 0;
  logic [8:0] ra [14] = '{9'h003, 9'h083, 9'h103, 9'h183, 9'h00B, 9'h08B,
    9'h10B, 9'h18B, 9'h081, 9'h181, 9'h08C, 9'h08D, 9'h00C, 9'h18C};
  logic [7:0] rv [14] = '{8'h18, 8'h18, 8'h18, 8'h18, 8'h00, 8'h00,
    8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
  csr_pkg::csr_alu_op_t ops [8] = '{csr_pkg::CSR_OP_ADD, csr_pkg::CSR_OP_ADD,
    csr_pkg::CSR_OP_ADD, csr_pkg::CSR_OP_SUB, csr_pkg::CSR_OP_SUB,
    csr_pkg::CSR_OP_LOGIC, csr_pkg::CSR_OP_ROR, csr_pkg::CSR_OP_ROL};
  logic [7:0] aa [8] = '{8'h0F, 8'hFF, 8'h00, 8'h10, 8'h01, 8'h00,
    8'h80, 8'h80};
  logic [7:0] bb [8] = '{8'h01, 8'h01, 8'h00, 8'h01, 8'h02, 8'h00,
    8'h00, 8'h00};
  logic [2:0] mm [8] = '{3'h7, 3'h7, 3'h0, 3'h7, 3'h7, 3'h4, 3'h1, 3'h1};
  logic [2:0] ee [8] = '{3'h2, 3'h7, 3'h7, 3'h1, 3'h0, 3'h4, 3'h4, 3'h5};

  always #5 clk = ~clk;

  csr_core_model i_core (.clk(clk), .rdata(rdata), .addr(addr), .wr(wr),
    .wdata(wdata), .rd(rd), .alu_en(alu_en), .alu_op(op), .alu_a(a),
    .alu_b(b), .alu_mask(m));

  csr_core_regs i_dut (.CLK(clk), .SYS_RST(rst), .REG_ADDR(addr),
    .REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata),
    .ALU_EN(alu_en), .ALU_OP(op), .ALU_A(a), .ALU_B(b), .ALU_FLAG_MASK(m),
    .CARRY(carry), .DIRECT_OFFSET(offs), .INDIRECT_POINTER(ptr),
    .DIRECT_ADDR(daddr), .INDIRECT_ADDR(iaddr), .KICK_EXEC(kick),
    .HALT_EXEC(halt), .WDT_TIMEOUT(wdto), .TIMER0_CLOCK_PIN(t0pin),
    .WDT_OSC_TICK(1'b1), .TIMER0_OVERFLOW(t0ov), .TIMER0_INC(t0inc),
    .WDT_TICK(wtick), .EXT_INTERRUPT_PIN(extp), .PORT_B_UPPER_PINS(pbu),
    .PORT_B_READ(pbr), .PORT_B_LATCH(latch), .PULLUP_EN(pull),
    .PERIPH_FLAGS(pflags), .IRQ(irq));

  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdc(input logic [8:0] ad, input logic [7:0] exp);
    i_core.rd_reg(ad, v);
    chk(v, exp);
  endtask : rdc

  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse

  // Bounded wait; running out of cycles is itself a mismatch
  task automatic wait_irq(input logic exp);
    int i;
    for (i = 0; i < 12 && irq !== exp; i++) @(negedge clk);
    chk(irq, exp);
  endtask : wait_irq

  task automatic cnt(input logic [7:0] opt, input int et, input int ew);
    int ct, cw;
    ct = 0;
    cw = 0;
    i_core.wr_reg(9'h081, opt);
    repeat (8) @(negedge clk);
    repeat (32) begin
      @(negedge clk);
      ct += t0inc;
      cw += wtick;
    end
    chk(ct, et);
    chk(cw, ew);
  endtask : cnt

  task automatic edge_cnt(input logic lvl, input int exp);
    int ct;
    ct = 0;
    t0pin = lvl;
    repeat (8) begin
      @(negedge clk);
      ct += t0inc;
    end
    chk(ct, exp);
  endtask : edge_cnt

  task tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    #200000;
    miscompares++;
    tally_and_finish;
  end

  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    foreach (ra[i]) rdc(ra[i], rv[i]);
    i_core.wr_reg(9'h003, 8'h00);
    rdc(9'h003, 8'h18);
    i_core.wr_reg(9'h183, 8'hE7);
    rdc(9'h083, 8'hFF);
    for (int k = 0; k < 8; k++) begin
      i_core.wr_reg(9'h003, {k[2:0], 5'h00});
      chk(daddr, {k[1:0], 7'h55});
      chk(iaddr, {k[2], 8'hA3});
    end
    for (int k = 0; k < 8; k++) begin
      i_core.alu_step(ops[k], aa[k], bb[k], mm[k], 1'b0);
      rdc(9'h003, {5'h1F, ee[k]});
    end
    i_core.alu_step(csr_pkg::CSR_OP_ADD, 8'hFF, 8'h01, 3'h7, 1'b1);
    rdc(9'h003, 8'h1F);
    pulse(halt);
    rdc(9'h003, 8'h17);
    pulse(wdto);
    rdc(9'h003, 8'h07);
    pulse(kick);
    rdc(9'h003, 8'h1F);
    chk(pull, 8'h00);
    i_core.wr_reg(9'h081, 8'h7F);
    chk(pull, 8'hA5);
    i_core.wr_reg(9'h081, 8'h40);
    i_core.wr_reg(9'h00B, 8'h90);
    extp = 1'b1;
    wait_irq(1'b1);
    rdc(9'h00B, 8'h92);
    i_core.wr_reg(9'h00B, 8'h90);
    wait_irq(1'b0);
    i_core.wr_reg(9'h081, 8'h00);
    extp = 1'b0;
    wait_irq(1'b1);
    i_core.wr_reg(9'h00B, 8'h00);
    pulse(t0ov);
    rdc(9'h00B, 8'h04);
    chk(irq, 1'b0);
    i_core.wr_reg(9'h00B, 8'hA4);
    chk(irq, 1'b1);
    i_core.wr_reg(9'h00B, 8'h88);
    chk(irq, 1'b0);
    pbu = 4'hA;
    wait_irq(1'b1);
    i_core.wr_reg(9'h00B, 8'h88);
    wait_irq(1'b1);
    pulse(pbr);
    i_core.wr_reg(9'h00B, 8'h88);
    rdc(9'h00B, 8'h88);
    for (int k = 0; k < 8; k++) begin
      pflags = 8'h01 << k;
      i_core.wr_reg(9'h00B, 8'hC0);
      i_core.wr_reg(9'h08C, pflags);
      chk(irq, 1'b1);
      i_core.wr_reg(9'h08C, ~pflags);
      chk(irq, 1'b0);
      i_core.wr_reg(9'h08C, pflags);
      i_core.wr_reg(9'h00B, 8'h80);
      chk(irq, 1'b0);
    end
    i_core.wr_reg(9'h00B, 8'h40);
    chk(irq, 1'b0);
    cnt(8'h00, 16, 32);
    cnt(8'h02, 4, 32);
    cnt(8'h0A, 32, 8);
    i_core.wr_reg(9'h081, 8'h28);
    edge_cnt(1'b1, 1);
    edge_cnt(1'b0, 0);
    i_core.wr_reg(9'h081, 8'h38);
    edge_cnt(1'b1, 0);
    edge_cnt(1'b0, 1);
    tally_and_finish;
  end
endmodule : csr_core_regs_test
